// ---- verilog/afe_cfg_pkg.sv ----
// Package with register map, field layout and reset values of the analog configuration bank
package afe_cfg_pkg;
  // Register indices on the bus (printed offsets are not all word multiples: byte address is index * 4)
  localparam logic [7:0] GAS_AMP_IDX = 8'h0d;
  localparam logic [7:0] REGULATOR_IDX = 8'h0f;
  localparam logic [7:0] PHOTO_CTRL_IDX = 8'h10;
  localparam logic [7:0] DAC_ONE_IDX = 8'h11;
  localparam logic [7:0] DAC_TWO_IDX = 8'h12;
  localparam int ADDR_W = 12;
  // Field positions
  localparam int REF_BUF_BIT = 7;
  localparam int GAS_REF_LSB = 5;
  localparam int GAS_FB_LSB = 3;
  localparam int GAS_DIR_BIT = 2;
  localparam int GAS_TEST_BIT = 1;
  localparam int GAS_AMP_BIT = 0;
  localparam int REG_SET_LSB = 1;
  localparam int TC_TWO_LSB = 5;
  localparam int TC_ONE_LSB = 3;
  localparam int PH_REF_BIT = 2;
  localparam int PH_GAIN_LSB = 0;
  // Writable bit masks; other bits are reserved
  localparam logic [7:0] GAS_AMP_MASK = 8'hff;
  localparam logic [7:0] REGULATOR_MASK = 8'h0e;
  localparam logic [7:0] PHOTO_CTRL_MASK = 8'h7f;
  localparam logic [7:0] DAC_MASK = 8'hff;
  // Reset values
  localparam logic [7:0] GAS_AMP_RST = 8'h00;
  localparam logic [7:0] REGULATOR_RST = 8'h00;
  localparam logic [7:0] PHOTO_CTRL_RST = 8'h00;
  localparam logic [7:0] DAC_RST = 8'h00;
endpackage

// ---- verilog/afe_analog_config_regs.sv ----
// Analog configuration register bank reached over APB, fields decoded onto analog controls
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module afe_analog_config_regs (
  input wire logic sys_clk, // 40 MHz clock
  input wire logic reset_n, // Asynchronous active-low reset
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write direction
  input wire logic [afe_cfg_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output logic ref_buffer_enable, // 300 mV reference buffer on
  output logic [1:0] gas_reference_select, // Gas amplifier reference code
  output logic [1:0] gas_feedback_select, // Gas amplifier feedback code
  output logic gas_test_direction, // 1 pull-up, 0 pull-down
  output logic gas_test_output_enable, // Gas test drive onto photo reference pin
  output logic gas_amplifier_enable, // Gas amplifier on
  output logic [2:0] emitter_regulator_setting, // Emitter regulator voltage code
  output logic [1:0] emitter_one_temp_coeff, // Emitter one temperature coefficient code
  output logic [1:0] emitter_two_temp_coeff, // Emitter two temperature coefficient code
  output logic photo_reference_select, // 1 selects 50 mV photo reference
  output logic [1:0] photo_gain_select, // Photo gain stage code
  output logic [7:0] emitter_one_dac_code, // Emitter one current DAC
  output logic [7:0] emitter_two_dac_code // Emitter two current DAC
);
  import afe_cfg_pkg::*;

  typedef struct packed {
    logic [7:0] gas_amp_config;
    logic [7:0] emitter_regulator_voltage;
    logic [7:0] photo_chain_control;
    logic [7:0] emitter_one_current_dac;
    logic [7:0] emitter_two_current_dac;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic rst_meta_r;
  logic rst_sync_n_r;

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = {{(ADDR_W-10){1'b0}}, idx, 2'b00};
  endfunction

  // Merge write data into a register under its writable mask
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (wd & mask);
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  // APB phase decode: setup cycle, and a write that lands at the end of this access cycle
  logic setup;
  logic wr_en;
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && st_r.ready && pstrb[0];

  // Next state: zero-wait-state APB slave, writes at the access edge
  always_comb begin
    st_nxt = st_r;
    st_nxt.ready = setup;
    st_nxt.err = 1'b0; // Error flag lives for the one access cycle only
    if (setup) begin
      st_nxt.rdata = 32'h0000_0000;
      if (paddr == reg_addr(GAS_AMP_IDX)) begin
        st_nxt.rdata[7:0] = st_r.gas_amp_config;
      end else if (paddr == reg_addr(REGULATOR_IDX)) begin
        st_nxt.rdata[7:0] = st_r.emitter_regulator_voltage & REGULATOR_MASK;
      end else if (paddr == reg_addr(PHOTO_CTRL_IDX)) begin
        st_nxt.rdata[7:0] = st_r.photo_chain_control & PHOTO_CTRL_MASK;
      end else if (paddr == reg_addr(DAC_ONE_IDX)) begin
        st_nxt.rdata[7:0] = st_r.emitter_one_current_dac;
      end else if (paddr == reg_addr(DAC_TWO_IDX)) begin
        st_nxt.rdata[7:0] = st_r.emitter_two_current_dac;
      end else begin
        st_nxt.err = 1'b1;
      end
    end
    if (wr_en) begin
      if (paddr == reg_addr(GAS_AMP_IDX)) begin
        st_nxt.gas_amp_config = merge(st_r.gas_amp_config, pwdata[7:0], GAS_AMP_MASK);
      end else if (paddr == reg_addr(REGULATOR_IDX)) begin
        st_nxt.emitter_regulator_voltage = merge(st_r.emitter_regulator_voltage, pwdata[7:0],
                                                 REGULATOR_MASK);
      end else if (paddr == reg_addr(PHOTO_CTRL_IDX)) begin
        st_nxt.photo_chain_control = merge(st_r.photo_chain_control, pwdata[7:0],
                                           PHOTO_CTRL_MASK);
      end else if (paddr == reg_addr(DAC_ONE_IDX)) begin
        st_nxt.emitter_one_current_dac = pwdata[7:0];
      end else if (paddr == reg_addr(DAC_TWO_IDX)) begin
        st_nxt.emitter_two_current_dac = pwdata[7:0];
      end
    end
  end

  // State register, all configuration cleared at reset
  always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      st_r.gas_amp_config <= GAS_AMP_RST;
      st_r.emitter_regulator_voltage <= REGULATOR_RST;
      st_r.photo_chain_control <= PHOTO_CTRL_RST;
      st_r.emitter_one_current_dac <= DAC_RST;
      st_r.emitter_two_current_dac <= DAC_RST;
      st_r.rdata <= 32'h0000_0000;
      st_r.ready <= 1'b0;
      st_r.err <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Bus answer straight from flip-flops
  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.err;

  // Gas amplifier field decode
  assign ref_buffer_enable = st_r.gas_amp_config[REF_BUF_BIT];
  assign gas_reference_select = st_r.gas_amp_config[GAS_REF_LSB +: 2];
  assign gas_feedback_select = st_r.gas_amp_config[GAS_FB_LSB +: 2];
  assign gas_test_direction = st_r.gas_amp_config[GAS_DIR_BIT];
  assign gas_test_output_enable = st_r.gas_amp_config[GAS_TEST_BIT];
  assign gas_amplifier_enable = st_r.gas_amp_config[GAS_AMP_BIT];

  // Regulator, photo chain and DAC field decode
  assign emitter_regulator_setting = st_r.emitter_regulator_voltage[REG_SET_LSB +: 3];
  assign emitter_two_temp_coeff = st_r.photo_chain_control[TC_TWO_LSB +: 2];
  assign emitter_one_temp_coeff = st_r.photo_chain_control[TC_ONE_LSB +: 2];
  assign photo_reference_select = st_r.photo_chain_control[PH_REF_BIT];
  assign photo_gain_select = st_r.photo_chain_control[PH_GAIN_LSB +: 2];
  assign emitter_one_dac_code = st_r.emitter_one_current_dac;
  assign emitter_two_dac_code = st_r.emitter_two_current_dac;

  // Per-register write strobes and address map hit, watched by the checks below
  logic gas_wr;
  logic reg_wr;
  logic photo_wr;
  logic dac_one_wr;
  logic dac_two_wr;
  logic wr_blocked;
  logic mapped;
  assign gas_wr = wr_en && paddr == reg_addr(GAS_AMP_IDX);
  assign reg_wr = wr_en && paddr == reg_addr(REGULATOR_IDX);
  assign photo_wr = wr_en && paddr == reg_addr(PHOTO_CTRL_IDX);
  assign dac_one_wr = wr_en && paddr == reg_addr(DAC_ONE_IDX);
  assign dac_two_wr = wr_en && paddr == reg_addr(DAC_TWO_IDX);
  assign wr_blocked = psel && penable && pwrite && st_r.ready && !pstrb[0];
  assign mapped = paddr == reg_addr(GAS_AMP_IDX) || paddr == reg_addr(REGULATOR_IDX)
    || paddr == reg_addr(PHOTO_CTRL_IDX) || paddr == reg_addr(DAC_ONE_IDX)
    || paddr == reg_addr(DAC_TWO_IDX);

  // Write to the gas register lands on all its outputs next cycle
  a_gas_write_lands: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    gas_wr |=> {ref_buffer_enable, gas_reference_select, gas_feedback_select,
    gas_test_direction, gas_test_output_enable, gas_amplifier_enable} == $past(pwdata[7:0]))
    else $error("gas register write not reflected");

  // Reserved regulator bits read back as zero
  a_reg_reserved_zero: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    setup && paddr == reg_addr(REGULATOR_IDX) |=> (prdata[7:0] & ~REGULATOR_MASK) == 8'h00)
    else $error("regulator reserved bit read as one");

  // Reserved photo control bit reads back as zero
  a_photo_reserved_zero: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    setup && paddr == reg_addr(PHOTO_CTRL_IDX) |=> !prdata[7])
    else $error("photo reserved bit read as one");

  // Regulator write lands in its three-bit field
  a_reg_write_field: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    reg_wr |=> emitter_regulator_setting == $past(pwdata[3:1]))
    else $error("regulator setting not written");

  // Photo control write lands in all four fields
  a_photo_write_fields: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    photo_wr |=> {emitter_two_temp_coeff, emitter_one_temp_coeff, photo_reference_select,
    photo_gain_select} == $past(pwdata[6:0]))
    else $error("photo fields not written");

  // Emitter one DAC keeps its code unless written
  a_dac_one_hold: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    !dac_one_wr |=> $stable(emitter_one_dac_code))
    else $error("emitter one DAC changed without write");

  // Emitter two DAC write lands and leaves emitter one alone
  a_dac_two_write: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    dac_two_wr |=> emitter_two_dac_code == $past(pwdata[7:0])
    && $stable(emitter_one_dac_code))
    else $error("emitter two DAC write wrong");

  // Ready is a one-cycle pulse right after the setup cycle
  a_ready_after_setup: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    setup |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");

  // Gas and regulator registers are clear while reset is held
  a_reset_zero: assert property (@(posedge sys_clk)
    !rst_sync_n_r |-> st_r.gas_amp_config == 8'h00 && emitter_regulator_setting == 3'h0)
    else $error("registers not zero in reset");

  // Gas controls change only through a write to their own register
  a_gas_hold_idle: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    !gas_wr |=> $stable({ref_buffer_enable, gas_reference_select, gas_feedback_select,
    gas_test_direction, gas_test_output_enable, gas_amplifier_enable}))
    else $error("gas controls changed without write");

  // Regulator setting changes only through its own register
  a_reg_hold_idle: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    !reg_wr |=> $stable(emitter_regulator_setting))
    else $error("regulator setting changed without write");

  // Photo chain controls change only through their own register
  a_photo_hold_idle: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    !photo_wr |=> $stable({emitter_two_temp_coeff, emitter_one_temp_coeff,
    photo_reference_select, photo_gain_select}))
    else $error("photo controls changed without write");

  // Emitter two DAC keeps its code unless written
  a_dac_two_hold: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    !dac_two_wr |=> $stable(emitter_two_dac_code))
    else $error("emitter two DAC changed without write");

  // Emitter one DAC write lands and leaves emitter two alone
  a_dac_one_write: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    dac_one_wr |=> emitter_one_dac_code == $past(pwdata[7:0])
    && $stable(emitter_two_dac_code))
    else $error("emitter one DAC write wrong");

  // A write with the low byte strobe off leaves every register as it was
  a_strobe_off_ignored: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    wr_blocked |=> $stable(st_r.gas_amp_config) && $stable(st_r.emitter_regulator_voltage)
    && $stable(st_r.photo_chain_control) && $stable(st_r.emitter_one_current_dac)
    && $stable(st_r.emitter_two_current_dac))
    else $error("register changed by strobe-off write");

  // Unmapped address answers with an error and zero data
  a_unmapped_error: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    setup && !mapped |=> pready && pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  // Mapped address answers without an error
  a_mapped_no_error: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    setup && mapped |=> pready && !pslverr)
    else $error("mapped access flagged as error");

  // Error flag only ever stands together with ready
  a_error_with_ready: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    pslverr |-> pready)
    else $error("error flag without ready");

  // Upper read data lanes are always zero
  a_read_upper_zero: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");

  // Gas register reads back what its controls show
  a_gas_read_back: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    setup && paddr == reg_addr(GAS_AMP_IDX) |=> prdata[7:0] == {ref_buffer_enable,
    gas_reference_select, gas_feedback_select, gas_test_direction, gas_test_output_enable,
    gas_amplifier_enable})
    else $error("gas read data differs from controls");

  // Regulator register reads back its setting
  a_reg_read_back: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    setup && paddr == reg_addr(REGULATOR_IDX) |=> prdata[3:1] == emitter_regulator_setting)
    else $error("regulator read data differs from setting");

  // Photo control register reads back its four fields
  a_photo_read_back: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    setup && paddr == reg_addr(PHOTO_CTRL_IDX) |=> prdata[6:0] == {emitter_two_temp_coeff,
    emitter_one_temp_coeff, photo_reference_select, photo_gain_select})
    else $error("photo read data differs from controls");

  // Emitter one DAC reads back its code
  a_dac_one_read: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    setup && paddr == reg_addr(DAC_ONE_IDX) |=> prdata[7:0] == emitter_one_dac_code)
    else $error("emitter one DAC read data wrong");

  // Emitter two DAC reads back its code
  a_dac_two_read: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    setup && paddr == reg_addr(DAC_TWO_IDX) |=> prdata[7:0] == emitter_two_dac_code)
    else $error("emitter two DAC read data wrong");

  // No ready without a selected transfer
  a_ready_idle_low: assert property (@(posedge sys_clk)
    disable iff (!rst_sync_n_r)
    !psel |=> !pready)
    else $error("ready raised while bus idle");

  // Photo chain, DAC codes and ready are clear while reset is held
  a_reset_photo_dac: assert property (@(posedge sys_clk)
    !rst_sync_n_r |-> {emitter_two_temp_coeff, emitter_one_temp_coeff, photo_reference_select,
    photo_gain_select, emitter_one_dac_code, emitter_two_dac_code} == 23'h00_0000 && !pready)
    else $error("photo or DAC controls not zero in reset");
endmodule
`default_nettype wire

// ---- testbench/apb_host_model.sv ----
// Host-side APB master model that drives the configuration bank
`timescale 1ns/100ps
`default_nettype none
module apb_host_model (
  input wire logic sys_clk, // Bus clock
  output logic psel, // Select
  output logic penable, // Access phase
  output logic pwrite, // Direction
  output logic [afe_cfg_pkg::ADDR_W-1:0] paddr, // Byte address
  output logic [31:0] pwdata, // Write data
  output logic [3:0] pstrb, // Byte strobes
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr // Error
);
  import afe_cfg_pkg::*;
  // Bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
  end
  // One transfer; call just after a rising edge, returns at the edge that saw pready
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Wait as long as the slave needs; only the bench watchdog ends a hung wait
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the analog configuration register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import afe_cfg_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  wire psel, penable, pwrite, pready, pslverr;
  wire [ADDR_W-1:0] paddr;
  wire [31:0] pwdata, prdata;
  wire [3:0] pstrb;
  wire [33:0] pins;
  logic [7:0] idx [6] = '{GAS_AMP_IDX, REGULATOR_IDX, PHOTO_CTRL_IDX, DAC_ONE_IDX,
                          DAC_TWO_IDX, 8'h0e};
  logic [7:0] msk [6] = '{GAS_AMP_MASK, REGULATOR_MASK, PHOTO_CTRL_MASK, DAC_MASK,
                          DAC_MASK, 8'h00};
  logic [7:0] shadow [6];
  int miscompares = 0;
  int n_compared = 0;
  int seed = 24315;
  // Clock at 40 MHz
  always #12.5 sys_clk = ~sys_clk;
  apb_host_model i_apb_host_model (.sys_clk(sys_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  afe_analog_config_regs i_afe_analog_config_regs (.sys_clk(sys_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_buffer_enable(pins[33]), .gas_reference_select(pins[32:31]),
    .gas_feedback_select(pins[30:29]), .gas_test_direction(pins[28]),
    .gas_test_output_enable(pins[27]), .gas_amplifier_enable(pins[26]),
    .emitter_regulator_setting(pins[25:23]), .emitter_two_temp_coeff(pins[22:21]),
    .emitter_one_temp_coeff(pins[20:19]), .photo_reference_select(pins[18]),
    .photo_gain_select(pins[17:16]), .emitter_one_dac_code(pins[15:8]),
    .emitter_two_dac_code(pins[7:0]));
  // Register index to bus byte address
  function automatic logic [ADDR_W-1:0] adr(input logic [7:0] ix);
    return {2'b00, ix, 2'b00};
  endfunction
  // Control pins expected from the register contents, field by field
  function automatic logic [33:0] want_pins();
    return {shadow[0], shadow[1][3:1], shadow[2][6:0], shadow[3], shadow[4]};
  endfunction
  task automatic complete_run;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cmp_read(input logic [32:0] got, input logic [32:0] want);
    n_compared++;
    if (got !== want) begin
      miscompares++;
      $display("mismatch at %0t: read %h expected %h", $time, got, want);
    end
  endtask
  task automatic cmp_err(input logic got, input logic want);
    n_compared++;
    if (got !== want) begin
      miscompares++;
      $display("mismatch at %0t: error flag %b expected %b", $time, got, want);
    end
  endtask
  task automatic cmp_pins();
    n_compared++;
    if (pins !== want_pins()) begin
      miscompares++;
      $display("mismatch at %0t: pins %h expected %h", $time, pins, want_pins());
    end
  endtask
  // Write one register, then check every control pin
  task automatic wr_reg(input int r, input logic [31:0] w, input logic [3:0] s);
    logic [31:0] rd;
    logic er;
    i_apb_host_model.xfer(1'b1, adr(idx[r]), w, s, rd, er);
    cmp_err(er, r == 5);
    if (s[0]) shadow[r] = w[7:0] & msk[r];
    @(posedge sys_clk);
    cmp_pins(); // to to
  endtask
  // Read one register; the unmapped slot answers with an error and zero
  task automatic rd_chk(input int r);
    logic [31:0] rd;
    logic er;
    i_apb_host_model.xfer(1'b0, adr(idx[r]), 32'($random(seed)), 4'hf, rd, er);
    cmp_read({er, rd}, {r == 5, 24'h0, shadow[r]});
    @(posedge sys_clk);
  endtask
  // Reset for three cycles, then all registers and pins must be zero
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    shadow = '{default: 8'h00};
    cmp_pins();
    for (int r = 0; r < 6; r++) rd_chk(r);
  endtask
  // Main sequence: corner values, random traffic, final reset
  initial begin
    do_reset();
    for (int i = 0; i < 120; i++) begin
      if (i < 12) wr_reg(i % 6, (i < 6) ? 32'hffffffff : 32'h0, 4'h1);
      else wr_reg(i % 6, 32'($random(seed)), 4'($random(seed)));
      rd_chk(i % 6);
    end
    do_reset();
    complete_run();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #(8000 * 25);
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
